// file: design/rmpu_regs.svh
// register offsets, field positions, reset values and options
`ifndef RMPU_REGS_SVH
`define RMPU_REGS_SVH
`define RMPU_MAX_REGIONS   32
`define RMPU_MIN_REGIONS   2
`define RMPU_DEF_REGIONS   8
`define RMPU_MIN_GRAN      64
`define RMPU_MAX_GRAN      1048576
`define RMPU_DEF_GRAN      4096
`define RMPU_SPACE_LG      31
`define RMPU_FIELD_W       26
`define RMPU_INDEX_W       5
`define RMPU_SEL_SELECT    1'b0
`define RMPU_SEL_ATTR      1'b1
`define RMPU_BASE_LSB      6
`define RMPU_INDEX_LSB     1
`define RMPU_DATA_BIT      0
`define RMPU_EXT_LSB       6
`define RMPU_CACHE_BIT     5
`define RMPU_RIGHTS_LSB    2
`define RMPU_RD_BIT        1
`define RMPU_WR_BIT        0
`define RMPU_RESET_VALUE   32'h00000000
`define RMPU_R_NONE        3'h0
`define RMPU_R_SUP         3'h1
`define RMPU_R_ALL         3'h2
`define RMPU_R_SW          3'h4
`define RMPU_R_SW_UR       3'h5
`define RMPU_R_RW          3'h6
`endif

// file: design/rmpu_pkg.sv
// types shared by the region protection unit
package rmpu_pkg;
  `include "rmpu_regs.svh"

  typedef struct packed {
    logic [`RMPU_FIELD_W-1:0] base;
    logic [`RMPU_FIELD_W-1:0] ext;
    logic [2:0]               rights;
    logic                     cache;
  } rmpu_region_t;

  typedef struct packed {
    logic [`RMPU_FIELD_W-1:0] base;
    logic [`RMPU_INDEX_W-1:0] index;
    logic                     data;
  } rmpu_sel_t;

  typedef struct packed {
    logic [`RMPU_FIELD_W-1:0] ext;
    logic                     cache;
    logic [2:0]               rights;
  } rmpu_attr_t;

  typedef struct packed {
    logic        req;
    logic [31:0] addr;
    logic        write;
    logic        user;
  } rmpu_acc_t;

  typedef struct packed {
    logic                                 enabled;
    rmpu_sel_t                            sel;
    rmpu_attr_t                           attr;
    rmpu_region_t [`RMPU_MAX_REGIONS-1:0] dreg;
    rmpu_region_t [`RMPU_MAX_REGIONS-1:0] ireg;
    logic [31:0]                          rdata;
    logic                                 d_done;
    logic                                 d_fault;
    logic                                 d_cache;
    logic                                 i_done;
    logic                                 i_fault;
  } rmpu_state_t;
endpackage

// file: design/rmpu.sv
// region memory protection unit: region banks, control registers, checks
// Behaviour
// - when enabled, every data access and fetch is checked; illegal ones fault
// - build option picks mask or end-limit regions, default mask
// - data region count is a parameter, 2 to 32, default 8
// - instruction region count is a parameter, 2 to 32, default 8
// - data granule is a parameter, 64 bytes to 1 MB, default 4 KB
// - instruction granule is a separate parameter, same range and default
// - granule sets map resolution; software sizes regions in granule multiples
// - select register has base, index, type fields, all reset zero
// - type bit one picks data bank, zero picks instruction bank
// - base field holds start address divided by granule
// - lower index wins where regions overlap
// - option decides whether attribute holds mask or limit field
// - no address translation; accesses only granted or denied
// - read-op bit loads selected region, write-op bit stores it
// - limit is granule address past region end; zero disables region
// - three-bit rights code gives supervisor and user rights
// - unit is disabled after reset until software enables it
module rmpu
  import rmpu_pkg::*;
#(
  parameter int USE_LIMIT = 0,
  parameter int D_REGIONS = `RMPU_DEF_REGIONS,
  parameter int I_REGIONS = `RMPU_DEF_REGIONS,
  parameter int D_GRAN    = `RMPU_DEF_GRAN,
  parameter int I_GRAN    = `RMPU_DEF_GRAN
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        enable_req,
  input  wire logic        ctl_wr,
  input  wire logic        ctl_rd,
  input  wire logic        ctl_sel,
  input  wire logic [31:0] ctl_wdata,
  output logic [31:0]      ctl_rdata,
  output logic             mpu_enabled,
  input  rmpu_acc_t        d_acc,
  output logic             d_done,
  output logic             d_fault,
  output logic             d_cacheable,
  input  rmpu_acc_t        i_acc,
  output logic             i_done,
  output logic             i_fault
);
  localparam int D_LG = $clog2(D_GRAN);
  localparam int I_LG = $clog2(I_GRAN);

  // refuse builds the logic cannot serve
  if (D_REGIONS < `RMPU_MIN_REGIONS || D_REGIONS > `RMPU_MAX_REGIONS)
    $error("data region count out of range");
  if (I_REGIONS < `RMPU_MIN_REGIONS || I_REGIONS > `RMPU_MAX_REGIONS)
    $error("instruction region count out of range");
  if (D_GRAN < `RMPU_MIN_GRAN || D_GRAN > `RMPU_MAX_GRAN
      || (1 << D_LG) != D_GRAN)
    $error("data granule illegal");
  if (I_GRAN < `RMPU_MIN_GRAN || I_GRAN > `RMPU_MAX_GRAN
      || (1 << I_LG) != I_GRAN)
    $error("instruction granule illegal");
  if (USE_LIMIT != 0 && USE_LIMIT != 1)
    $error("limit option must be 0 or 1");

  rmpu_state_t s;
  rmpu_state_t next_s;

  // region match in granule units, mask or limit form
  function automatic logic region_hit(rmpu_region_t r,
                                      logic [`RMPU_FIELD_W-1:0] a,
                                      int lg);
    logic [`RMPU_FIELD_W-1:0] top;
    top = `RMPU_FIELD_W'({`RMPU_FIELD_W{1'b1}} << (`RMPU_SPACE_LG - lg));
    if (USE_LIMIT != 0)
      region_hit = (r.ext != '0) && (a >= r.base) && (a < r.ext);
    else
      // mask bit set above the address space marks a disabled region
      region_hit = ~|(r.ext & top) && (((a ^ r.base) & r.ext) == '0);
  endfunction

  function automatic logic rights_ok(logic [2:0] p, logic instr,
                                     logic wr, logic user);
    rights_ok = 1'b0;
    if (instr)
      rights_ok = user ? (p == `RMPU_R_ALL)
                       : (p == `RMPU_R_SUP || p == `RMPU_R_ALL);
    else if (wr)
      rights_ok = user ? (p == `RMPU_R_RW)
                       : (p == `RMPU_R_SW || p == `RMPU_R_SW_UR
                          || p == `RMPU_R_RW);
    else
      rights_ok = user ? (p == `RMPU_R_ALL || p == `RMPU_R_SW_UR
                          || p == `RMPU_R_RW)
                       : (p == `RMPU_R_SUP || p == `RMPU_R_ALL
                          || p == `RMPU_R_SW || p == `RMPU_R_SW_UR
                          || p == `RMPU_R_RW);
  endfunction

  logic [30:0]              d_shift;
  logic [30:0]              i_shift;
  logic [`RMPU_FIELD_W-1:0] d_gaddr;
  logic [`RMPU_FIELD_W-1:0] i_gaddr;
  logic                     d_hit;
  logic                     i_hit;
  logic [2:0]               d_rights;
  logic [2:0]               i_rights;
  logic                     d_c;
  logic                     op_rd;
  logic                     op_wr;
  logic                     idx_ok;
  rmpu_region_t             sel_region;
  rmpu_region_t             new_region;

  // address is compared only, never altered or passed on
  assign d_shift = d_acc.addr[30:0] >> D_LG;
  assign i_shift = i_acc.addr[30:0] >> I_LG;
  assign d_gaddr = d_shift[`RMPU_FIELD_W-1:0];
  assign i_gaddr = i_shift[`RMPU_FIELD_W-1:0];

  always_comb begin
    next_s = s;
    next_s.enabled = enable_req;
    d_hit = 1'b0;
    d_rights = `RMPU_R_NONE;
    d_c = 1'b0;
    // walk from high index down so the lowest matching index wins
    for (int k = D_REGIONS - 1; k >= 0; k--) begin
      if (region_hit(s.dreg[k], d_gaddr, D_LG)) begin
        d_hit = 1'b1;
        d_rights = s.dreg[k].rights;
        d_c = s.dreg[k].cache;
      end
    end
    i_hit = 1'b0;
    i_rights = `RMPU_R_NONE;
    for (int k = I_REGIONS - 1; k >= 0; k--) begin
      if (region_hit(s.ireg[k], i_gaddr, I_LG)) begin
        i_hit = 1'b1;
        i_rights = s.ireg[k].rights;
      end
    end
    next_s.d_done = d_acc.req;
    next_s.i_done = i_acc.req;
    next_s.d_fault = d_acc.req && s.enabled
                     && !(d_hit && rights_ok(d_rights, 1'b0, d_acc.write,
                                             d_acc.user));
    next_s.d_cache = d_acc.req && s.enabled && d_hit && d_c;
    next_s.i_fault = i_acc.req && s.enabled
                     && !(i_hit && rights_ok(i_rights, 1'b1, 1'b0,
                                             i_acc.user));

    // region control: select register and attribute operations
    op_rd = ctl_wdata[`RMPU_RD_BIT];
    op_wr = ctl_wdata[`RMPU_WR_BIT];
    idx_ok = s.sel.data ? ({1'b0, s.sel.index} < 6'(D_REGIONS))
                        : ({1'b0, s.sel.index} < 6'(I_REGIONS));
    sel_region = s.sel.data ? s.dreg[s.sel.index]
                            : s.ireg[s.sel.index];
    new_region.base = s.sel.base;
    new_region.ext = ctl_wdata[`RMPU_EXT_LSB +: `RMPU_FIELD_W];
    new_region.rights = ctl_wdata[`RMPU_RIGHTS_LSB +: 3];
    new_region.cache = ctl_wdata[`RMPU_CACHE_BIT];
    if (ctl_wr && ctl_sel == `RMPU_SEL_SELECT) begin
      next_s.sel.base = ctl_wdata[`RMPU_BASE_LSB +: `RMPU_FIELD_W];
      next_s.sel.index = ctl_wdata[`RMPU_INDEX_LSB +: `RMPU_INDEX_W];
      next_s.sel.data = ctl_wdata[`RMPU_DATA_BIT];
    end
    if (ctl_wr && ctl_sel == `RMPU_SEL_ATTR) begin
      next_s.attr.ext = new_region.ext;
      next_s.attr.cache = new_region.cache;
      next_s.attr.rights = new_region.rights;
      // both op bits at once is left as a plain attribute write
      if (op_rd && !op_wr && idx_ok) begin
        next_s.sel.base = sel_region.base;
        next_s.attr.ext = sel_region.ext;
        next_s.attr.cache = sel_region.cache;
        next_s.attr.rights = sel_region.rights;
      end
      if (op_wr && !op_rd && idx_ok) begin
        if (s.sel.data)
          next_s.dreg[s.sel.index] = new_region;
        else
          next_s.ireg[s.sel.index] = new_region;
      end
    end
    if (ctl_rd) begin
      // op bits are write-only and read as zero
      if (ctl_sel == `RMPU_SEL_ATTR)
        next_s.rdata = {s.attr.ext, s.attr.cache, s.attr.rights, 2'b00};
      else
        next_s.rdata = {s.sel.base, s.sel.index, s.sel.data};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst)
      s <= '0;
    else
      s <= next_s;
  end

  assign ctl_rdata = s.rdata;
  assign mpu_enabled = s.enabled;
  assign d_done = s.d_done;
  assign d_fault = s.d_fault;
  assign d_cacheable = s.d_cache;
  assign i_done = s.i_done;
  assign i_fault = s.i_fault;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_stay_off;
    !enable_req |=> !mpu_enabled;
  endproperty
  a_stay_off: assert property (p_stay_off)
    else $error("unit enabled without request");

  property p_off_no_fault;
    (d_acc.req && !s.enabled) |=> (d_done && !d_fault);
  endproperty
  a_off_no_fault: assert property (p_off_no_fault)
    else $error("fault raised while disabled");

  property p_nohit_fault;
    (d_acc.req && s.enabled && !d_hit) |=> d_fault;
  endproperty
  a_nohit_fault: assert property (p_nohit_fault)
    else $error("unmatched data access not faulted");

  property p_user_write;
    (d_acc.req && s.enabled && d_acc.write && d_acc.user
     && d_rights != `RMPU_R_RW) |=> d_fault;
  endproperty
  a_user_write: assert property (p_user_write)
    else $error("user write allowed without full rights");

  property p_user_fetch;
    (i_acc.req && s.enabled && i_acc.user
     && !(i_hit && i_rights == `RMPU_R_ALL)) |=> i_fault;
  endproperty
  a_user_fetch: assert property (p_user_fetch)
    else $error("user fetch allowed without execute rights");

  property p_priority;
    (d_acc.req && s.enabled && region_hit(s.dreg[0], d_gaddr, D_LG)
     && s.dreg[0].rights == `RMPU_R_NONE) |=> d_fault;
  endproperty
  a_priority: assert property (p_priority)
    else $error("region zero did not take precedence");

  property p_store;
    (ctl_wr && ctl_sel == `RMPU_SEL_ATTR && op_wr && !op_rd && idx_ok
     && s.sel.data && s.sel.index == '0)
    |=> (s.dreg[0].ext == $past(new_region.ext)
         && s.dreg[0].base == $past(s.sel.base));
  endproperty
  a_store: assert property (p_store)
    else $error("region store lost");

  property p_load;
    (ctl_wr && ctl_sel == `RMPU_SEL_ATTR && op_rd && !op_wr && idx_ok)
    ##1 (ctl_rd && ctl_sel == `RMPU_SEL_ATTR && !ctl_wr)
    |=> ctl_rdata[31:`RMPU_EXT_LSB] == $past(sel_region.ext, 2);
  endproperty
  a_load: assert property (p_load)
    else $error("region load did not reach attribute register");

  property p_op_bits_zero;
    (ctl_rd && ctl_sel == `RMPU_SEL_ATTR) |=> ctl_rdata[1:0] == 2'b00;
  endproperty
  a_op_bits_zero: assert property (p_op_bits_zero)
    else $error("op bits read back nonzero");

  property p_zero_limit;
    (USE_LIMIT != 0 && s.dreg[0].ext == '0)
    |-> !region_hit(s.dreg[0], d_gaddr, D_LG);
  endproperty
  a_zero_limit: assert property (p_zero_limit)
    else $error("zero limit region matched");

  property p_data_done;
    d_acc.req |=> d_done;
  endproperty
  a_data_done: assert property (p_data_done)
    else $error("data access not answered");

  property p_fetch_done;
    i_acc.req |=> i_done;
  endproperty
  a_fetch_done: assert property (p_fetch_done)
    else $error("fetch not answered");

  property p_fetch_off;
    (i_acc.req && !s.enabled) |=> (i_done && !i_fault);
  endproperty
  a_fetch_off: assert property (p_fetch_off)
    else $error("fetch fault raised while disabled");

  c_data_fault: cover property (d_acc.req && s.enabled ##1 d_fault);
  c_data_pass: cover property (d_acc.req && s.enabled && d_hit ##1 !d_fault);
  c_fetch_fault: cover property (i_acc.req && s.enabled ##1 i_fault);
  c_store: cover property (ctl_wr && ctl_sel && op_wr && idx_ok);
endmodule

// file: verif/rmpu_core_model.sv
// processor-side load/store and fetch issuer for the protection unit
module rmpu_core_model
  import rmpu_pkg::*;
(
  input  wire logic clk_sys,
  output rmpu_acc_t d_acc,
  output rmpu_acc_t i_acc,
  input  wire logic d_done,
  input  wire logic d_fault,
  input  wire logic d_cacheable,
  input  wire logic i_done,
  input  wire logic i_fault
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    d_acc = '0;
    i_acc = '0;
  end

  // one access per call, address sent untranslated; res is done,fault,cache
  task automatic access(input logic ins, input logic [31:0] a,
                        input logic w, input logic u,
                        output logic [2:0] res);
    rmpu_acc_t r;
    r = '{req: 1'b1, addr: a, write: w, user: u};
    @(posedge clk_sys);
    if (ins) i_acc <= r;
    else d_acc <= r;
    @(posedge clk_sys);
    // idle lines show the inverse so stale values never pass
    r = '{req: 1'b0, addr: ~a, write: ~w, user: ~u};
    d_acc <= r;
    i_acc <= r;
    #1;
    res = ins ? {i_done, i_fault, 1'b0} : {d_done, d_fault, d_cacheable};
  endtask
endmodule

// file: verif/rmpu_tb_top.sv
// self-checking bench for the region protection unit
module rmpu_tb_top
  import rmpu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_sys;
  logic        rst;
  logic        enable_req;
  logic        ctl_wr;
  logic        ctl_rd;
  logic        ctl_sel;
  logic [31:0] ctl_wdata;
  logic [31:0] ctl_rdata;
  logic        mpu_enabled;
  rmpu_acc_t   d_acc;
  rmpu_acc_t   i_acc;
  logic        d_done;
  logic        d_fault;
  logic        d_cacheable;
  logic        i_done;
  logic        i_fault;
  logic        mpu_enabled_l;
  logic        d_done_l;
  logic        d_fault_l;
  logic        d_cacheable_l;
  logic        i_done_l;
  logic        i_fault_l;
  int          miscompares;
  int          num_checks;

  // small data granule, default fetch granule, short banks
  rmpu #(.D_REGIONS(4), .I_REGIONS(2), .D_GRAN(64), .I_GRAN(4096)) rmpu_i (
    .clk_sys(clk_sys), .rst(rst), .enable_req(enable_req),
    .ctl_wr(ctl_wr), .ctl_rd(ctl_rd), .ctl_sel(ctl_sel),
    .ctl_wdata(ctl_wdata), .ctl_rdata(ctl_rdata),
    .mpu_enabled(mpu_enabled), .d_acc(d_acc), .d_done(d_done),
    .d_fault(d_fault), .d_cacheable(d_cacheable), .i_acc(i_acc),
    .i_done(i_done), .i_fault(i_fault));

  rmpu_core_model rmpu_core_model_i (
    .clk_sys(clk_sys), .d_acc(d_acc), .i_acc(i_acc), .d_done(d_done),
    .d_fault(d_fault), .d_cacheable(d_cacheable), .i_done(i_done),
    .i_fault(i_fault));

  // same stimulus into a limit-mode build; its outputs are judged apart
  if (1) begin : g_lim
    rmpu #(.USE_LIMIT(1), .D_REGIONS(4), .I_REGIONS(2), .D_GRAN(64),
           .I_GRAN(4096)) rmpu_i (
      .clk_sys(clk_sys), .rst(rst), .enable_req(enable_req),
      .ctl_wr(ctl_wr), .ctl_rd(ctl_rd), .ctl_sel(ctl_sel),
      .ctl_wdata(ctl_wdata), .ctl_rdata(),
      .mpu_enabled(mpu_enabled_l), .d_acc(d_acc), .d_done(d_done_l),
      .d_fault(d_fault_l), .d_cacheable(d_cacheable_l), .i_acc(i_acc),
      .i_done(i_done_l), .i_fault(i_fault_l));
  end

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic final_report;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s exp %h got %h", what, e, g);
    end
  endtask

  task automatic wr(input logic s, input logic [31:0] d);
    @(posedge clk_sys);
    ctl_wr    <= 1'b1;
    ctl_sel   <= s;
    ctl_wdata <= d;
    @(posedge clk_sys);
    ctl_wr    <= 1'b0;
    ctl_wdata <= ~d;
  endtask

  task automatic rd(input logic s, input logic [31:0] e);
    @(posedge clk_sys);
    ctl_rd  <= 1'b1;
    ctl_sel <= s;
    @(posedge clk_sys);
    ctl_rd <= 1'b0;
    @(posedge clk_sys);
    #1;
    check("ctl_rdata", e, ctl_rdata);
  endtask

  // load op followed at once by the read, as a core would issue them
  task automatic ld(input logic [31:0] e);
    @(posedge clk_sys);
    ctl_wr    <= 1'b1;
    ctl_sel   <= 1'b1;
    ctl_wdata <= 32'h00000002;
    @(posedge clk_sys);
    ctl_wr    <= 1'b0;
    ctl_rd    <= 1'b1;
    ctl_wdata <= 32'hFFFFFFFD;
    @(posedge clk_sys);
    ctl_rd <= 1'b0;
    #1;
    check("ctl_rdata", e, ctl_rdata);
  endtask

  // disable first: config is only written with the unit off
  task automatic en(input logic v);
    @(posedge clk_sys);
    enable_req <= v;
    repeat (2) @(posedge clk_sys);
  endtask

  task automatic prog(input logic d, input logic [4:0] idx,
                      input logic [25:0] base, ext,
                      input logic [2:0] rights, input logic c);
    wr(1'b0, {base, idx, d});
    wr(1'b1, {ext, c, rights, 2'b01});
  endtask

  task automatic acc(input logic ins, input logic [31:0] a,
                     input logic w, u, input logic [2:0] e);
    logic [2:0] r;
    rmpu_core_model_i.access(ins, a, w, u, r);
    check("access", {29'h0, e}, {29'h0, r});
  endtask

  // access judged on the limit-mode build, outputs stand one cycle
  task automatic lacc(input logic ins, input logic [31:0] a,
                      input logic w, u, input logic [2:0] e);
    logic [2:0] r;
    rmpu_core_model_i.access(ins, a, w, u, r);
    r = ins ? {i_done_l, i_fault_l, 1'b0}
            : {d_done_l, d_fault_l, d_cacheable_l};
    check("limit access", {29'h0, e}, {29'h0, r});
  endtask

  function automatic logic dperm(input logic [2:0] c, input logic w, u);
    case ({w, u})
      2'b00: return c inside {3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
      2'b01: return c inside {3'h2, 3'h5, 3'h6};
      2'b10: return c inside {3'h4, 3'h5, 3'h6};
      default: return c == 3'h6;
    endcase
  endfunction

  task automatic test_reset;
    check("mpu_enabled", 32'h0, {31'h0, mpu_enabled});
    rd(1'b0, 32'h0);
    rd(1'b1, 32'h0);
    acc(1'b0, 32'h00001000, 1'b1, 1'b1, 3'b100);
    acc(1'b1, 32'h00000000, 1'b0, 1'b1, 3'b100);
    $display("test reset done");
  endtask

  task automatic test_regs;
    prog(1'b1, 5'd1, 26'h0, 26'h1FFFF80, 3'h6, 1'b1);
    wr(1'b0, {26'h155, 5'd1, 1'b1});
    ld({26'h1FFFF80, 1'b1, 3'h6, 2'b00});
    rd(1'b0, {26'h0, 5'd1, 1'b1});
    $display("test regs done");
  endtask

  task automatic test_map;
    prog(1'b1, 5'd0, 26'h40, 26'h1FFFFFF, 3'h0, 1'b0);
    prog(1'b1, 5'd2, 26'h1, 26'h2000000, 3'h6, 1'b0);
    prog(1'b1, 5'd3, 26'h1, 26'h2000000, 3'h6, 1'b0);
    prog(1'b0, 5'd0, 26'h0, 26'h7FFFF, 3'h2, 1'b0);
    prog(1'b0, 5'd1, 26'h1, 26'h80000, 3'h2, 1'b0);
    en(1'b1);
    check("mpu_enabled", 32'h1, {31'h0, mpu_enabled});
    acc(1'b0, 32'h00001000, 1'b0, 1'b0, 3'b110);
    acc(1'b0, 32'h00001040, 1'b1, 1'b1, 3'b101);
    acc(1'b0, 32'h00003000, 1'b0, 1'b0, 3'b110);
    acc(1'b1, 32'h00000FFC, 1'b0, 1'b1, 3'b100);
    acc(1'b1, 32'h00001000, 1'b0, 1'b0, 3'b110);
    $display("test map done");
  endtask

  task automatic test_rights;
    logic [2:0] r;
    for (int c = 0; c < 8; c++) begin
      en(1'b0);
      prog(1'b1, 5'd1, 26'h0, 26'h1FFFF80, c[2:0], 1'b1);
      prog(1'b0, 5'd0, 26'h0, 26'h7FFFF, c[2:0], 1'b0);
      en(1'b1);
      for (int k = 0; k < 4; k++) begin
        rmpu_core_model_i.access(1'b0, 32'h1040, k[1], k[0], r);
        check("data", {31'h1, ~dperm(c[2:0], k[1], k[0])}, r[2:1]);
      end
      acc(1'b1, 32'h10, 1'b0, 1'b0, {1'b1, !(c inside {1, 2}), 1'b0});
      acc(1'b1, 32'h10, 1'b0, 1'b1, {1'b1, c != 2, 1'b0});
    end
    $display("test rights done");
  endtask

  task automatic test_limit;
    en(1'b0);
    prog(1'b1, 5'd0, 26'h40, 26'h41, 3'h0, 1'b0);
    prog(1'b1, 5'd1, 26'h40, 26'h80, 3'h6, 1'b1);
    prog(1'b1, 5'd2, 26'h1, 26'h0, 3'h6, 1'b0);
    prog(1'b1, 5'd3, 26'h1, 26'h0, 3'h6, 1'b0);
    prog(1'b0, 5'd0, 26'h0, 26'h1, 3'h2, 1'b0);
    prog(1'b0, 5'd1, 26'h1, 26'h0, 3'h2, 1'b0);
    en(1'b1);
    check("mpu_enabled_l", 32'h1, {31'h0, mpu_enabled_l});
    lacc(1'b0, 32'h00001000, 1'b0, 1'b0, 3'b110);
    lacc(1'b0, 32'h00001040, 1'b1, 1'b1, 3'b101);
    lacc(1'b0, 32'h00002000, 1'b0, 1'b0, 3'b110);
    lacc(1'b0, 32'h00000FC0, 1'b0, 1'b0, 3'b110);
    lacc(1'b1, 32'h00000FFC, 1'b0, 1'b1, 3'b100);
    lacc(1'b1, 32'h00001000, 1'b0, 1'b0, 3'b110);
    $display("test limit done");
  endtask

  initial begin
    miscompares = 0;
    num_checks  = 0;
    rst         = 1'b1;
    enable_req  = 1'b0;
    ctl_wr      = 1'b0;
    ctl_rd      = 1'b0;
    ctl_sel     = 1'b0;
    ctl_wdata   = 32'h0;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    test_reset();
    test_regs();
    test_map();
    test_rights();
    test_limit();
    // reset again mid-run: written fields must fall back to zero
    @(posedge clk_sys);
    rst        <= 1'b1;
    enable_req <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    test_reset();
    final_report();
  end

  // all tests fit in well under 2000 cycles
  initial begin
    repeat (8000) @(posedge clk_sys);
    miscompares++;
    final_report();
  end
endmodule
